/* hw/two_wire_pkg.sv */
// shared constants, states and carriers of the two-wire bus protocol engine
package two_wire_pkg;

	// ------------------------------------------------------------
	// widths, counts and addresses
	// ------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int RX_FIFO_DEPTH = 16;
	localparam logic [15:0] HALF_BASE = 16'h0008;
	localparam logic [15:0] SYNC_LAT = 16'h0003;
	localparam logic [15:0] PRESC_1 = 16'h0001;
	localparam logic [15:0] PRESC_4 = 16'h0004;
	localparam logic [15:0] PRESC_16 = 16'h0010;
	localparam logic [15:0] PRESC_64 = 16'h0040;
	localparam logic [3:0] BIT_LAST_DATA = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [6:0] GC_ADDR = 7'h00;
	localparam logic [3:0] RESERVED_HI = 4'hF;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] BIT_RST = 4'h0;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ------------------------------------------------------------
	// commands and states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_START = 2'b00,
		OP_WRITE = 2'b01,
		OP_READ = 2'b10,
		OP_STOP = 2'b11
	} op_t;

	typedef enum logic [3:0] {
		M_IDLE = 4'b0000,
		M_START = 4'b0001,
		M_LOW = 4'b0010,
		M_HIGH = 4'b0011,
		M_HOLD = 4'b0100,
		M_STOP_A = 4'b0101,
		M_STOP_B = 4'b0110,
		M_STOP_C = 4'b0111,
		M_RS_A = 4'b1000,
		M_RS_B = 4'b1001
	} master_state_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_ACK = 3'b010,
		S_RX = 3'b011,
		S_TX = 3'b100,
		S_TXACK = 3'b101,
		S_WAIT = 3'b110
	} slave_state_t;

	typedef struct packed {
		op_t op;
		logic [7:0] data;
		logic nack;
	} cmd_t;

	typedef struct packed {
		logic bus_busy;
		logic ack_received;
		logic addressed;
		logic general_call;
		logic slave_read;
		logic master_ack_seen;
	} status_t;

endpackage

/* hw/sync_fifo.sv */
// synchronous FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	logic push;
	logic pop;

	// the output register counts as one slot, so the total stays DEPTH
	assign in_ready = (cnt_q + (AW + 1)'(out_valid_q)) < FULL_CNT;
	assign push = in_valid & in_ready;
	assign pop = (cnt_q != '0) & (~out_valid_q | out_ready);
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else if (pop) begin
			out_valid_q <= 1'b1;
			out_data_q <= mem_q[rd_q];
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* hw/two_wire_bus_protocol_engine.sv */
// two-wire bus protocol engine: master and slave bit and frame logic with a receive FIFO
// ------------------------------------------------------------
// Behaviour
// RULE1: one clock pulse per bit; data steady while clock is high
// RULE2: start and stop only by data change while clock is high
// RULE3: master frames transfers with start and stop; bus busy in between
// RULE4: repeated start keeps the bus; busy until next stop
// RULE5: address packet is seven address bits, direction bit, acknowledge bit
// RULE6: direction one means read, zero means write
// RULE7: addressed slave pulls data low in ninth clock; busy slave leaves high
// RULE8: after an unacknowledged address the master may stop or restart
// RULE9: bytes go out most significant bit first
// RULE10: address zero with write is general call for enabled slaves
// RULE11: masters never send general call with read direction
// RULE12: addresses 1111xxx are reserved and never answered
// RULE13: data packet is eight data bits and one acknowledge bit
// RULE14: master makes clock and conditions; receiver acknowledges in ninth cycle
// RULE15: receiver that cannot take more answers the last byte with not-acknowledge
// RULE16: a transfer is start, address, data packets, stop; never start-stop
// RULE17: slave may hold clock low; master waits, keeps its high time
// RULE18: lines are only pulled low or released, never driven high
// RULE19: interface stays inert while the power-off bit is set
// RULE20: start is data falling, stop is data rising, both with clock high
// RULE21: master clock period is sixteen plus twice divider times prescaler
// RULE22: slave ignores bit-rate settings but needs sixteen-fold system clock
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_protocol_engine
	import two_wire_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic two_wire_power_off_bit,
	input wire logic [7:0] bit_rate_divider,
	input wire logic [1:0] prescale_sel,
	input wire logic [6:0] own_address,
	input wire logic general_call_enable,
	input wire logic slave_ack_enable,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire cmd_t cmd,
	output logic cmd_done,
	input wire logic slave_tx_valid,
	output logic slave_tx_ready,
	input wire logic [7:0] slave_tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output status_t status,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);

	// ------------------------------------------------------------
	// reset release and pin synchronisers
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n_q;
	logic scl_meta_q;
	logic scl_s_q;
	logic scl_prev_q;
	logic sda_meta_q;
	logic sda_s_q;
	logic sda_prev_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			scl_meta_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_prev_q <= 1'b1;
			sda_meta_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_meta_q <= scl_in;
			scl_s_q <= scl_meta_q;
			scl_prev_q <= scl_s_q;
			sda_meta_q <= sda_in;
			sda_s_q <= sda_meta_q;
			sda_prev_q <= sda_s_q;
		end
	end

	logic enable;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign enable = ~two_wire_power_off_bit; // RULE19
	assign scl_rise = scl_s_q & ~scl_prev_q;
	assign scl_fall = ~scl_s_q & scl_prev_q;
	// a data edge only counts when the clock was high on both samples
	assign start_det = scl_s_q & scl_prev_q & sda_prev_q & ~sda_s_q; // RULE20 RULE2
	assign stop_det = scl_s_q & scl_prev_q & ~sda_prev_q & sda_s_q; // RULE20 RULE2

	// ------------------------------------------------------------
	// bus busy tracking
	// ------------------------------------------------------------
	logic bus_busy_q;

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bus_busy_q <= 1'b0;
		end else if (!enable || stop_det) begin
			bus_busy_q <= 1'b0; // RULE3
		end else if (start_det) begin
			bus_busy_q <= 1'b1; // RULE3 RULE4
		end
	end

	// ------------------------------------------------------------
	// bit-rate generator
	// ------------------------------------------------------------
	logic [15:0] presc_w;
	logic [15:0] half_w;

	always_comb begin
		case (prescale_sel)
			2'b00: presc_w = PRESC_1;
			2'b01: presc_w = PRESC_4;
			2'b10: presc_w = PRESC_16;
			default: presc_w = PRESC_64;
		endcase
	end

	// half period, so a full clock is 16 + 2 * divider * prescaler cycles
	assign half_w = HALF_BASE + 16'(bit_rate_divider) * presc_w; // RULE21

	// ------------------------------------------------------------
	// master sequencer
	// ------------------------------------------------------------
	master_state_t m_state_q;
	logic [15:0] m_cnt_q;
	logic [3:0] m_bit_q;
	logic [7:0] m_shift_q;
	logic m_rx_q;
	logic m_nack_q;
	logic m_ack_q;
	logic m_half;
	logic m_hi_done;
	logic m_timed_hi;
	logic m_push;
	logic fifo_in_ready;
	logic cmd_take;
	logic done_d;
	slave_state_t s_state_q;

	assign cmd_ready = enable & (m_state_q == M_HOLD
		| (m_state_q == M_IDLE & ~bus_busy_q & s_state_q == S_IDLE)); // RULE3
	assign cmd_take = cmd_valid & cmd_ready;
	assign m_half = m_cnt_q >= half_w - 16'h0001;
	assign m_timed_hi = m_state_q == M_HIGH | m_state_q == M_STOP_B | m_state_q == M_RS_B;
	// high time only ends once the line is seen high, so a stretching slave wins
	assign m_hi_done = m_half & scl_s_q; // RULE17
	assign m_push = m_state_q == M_HIGH & m_rx_q & m_bit_q == BIT_LAST_DATA & m_hi_done;

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			m_cnt_q <= CNT_RST;
		end else if (cmd_take || !enable) begin
			m_cnt_q <= CNT_RST;
		end else if (m_timed_hi) begin
			// the sync delay is allowed to pass before stretching is judged
			if (m_hi_done) begin
				m_cnt_q <= (m_push && !fifo_in_ready) ? m_cnt_q : CNT_RST;
			end else if (scl_s_q || m_cnt_q < SYNC_LAT) begin
				m_cnt_q <= m_cnt_q + 16'h0001; // RULE17
			end
		end else if (m_state_q == M_IDLE || m_state_q == M_HOLD || m_half) begin
			m_cnt_q <= CNT_RST;
		end else begin
			m_cnt_q <= m_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			m_state_q <= M_IDLE;
			m_bit_q <= BIT_RST;
			m_shift_q <= BYTE_RST;
			m_rx_q <= 1'b0;
			m_nack_q <= 1'b0;
			m_ack_q <= 1'b0;
		end else if (!enable) begin
			m_state_q <= M_IDLE;
		end else begin
			case (m_state_q)
				M_IDLE: begin
					// the start command always carries the address packet
					if (cmd_take && cmd.op == OP_START) begin
						m_shift_q <= cmd.data;
						m_rx_q <= 1'b0;
						m_state_q <= M_START; // RULE3 RULE16
					end
				end
				M_HOLD: begin
					if (cmd_take) begin
						m_bit_q <= BIT_RST;
						m_shift_q <= cmd.data;
						m_rx_q <= cmd.op == OP_READ;
						m_nack_q <= cmd.nack;
						case (cmd.op)
							OP_START: m_state_q <= M_RS_A; // RULE4 RULE8
							OP_STOP: m_state_q <= M_STOP_A; // RULE8
							default: m_state_q <= M_LOW; // RULE13
						endcase
					end
				end
				M_START: begin
					if (m_half) begin
						m_bit_q <= BIT_RST;
						m_state_q <= M_LOW;
					end
				end
				M_LOW: begin
					if (m_half) begin
						m_state_q <= M_HIGH;
					end
				end
				M_HIGH: begin
					if (m_hi_done && !(m_push && !fifo_in_ready)) begin
						if (m_bit_q == BIT_ACK) begin
							m_ack_q <= ~sda_s_q; // RULE14
							m_state_q <= M_HOLD;
						end else begin
							m_shift_q <= {m_shift_q[6:0], sda_s_q}; // RULE9
							m_bit_q <= m_bit_q + 4'h1; // RULE5 RULE13
							m_state_q <= M_LOW;
						end
					end
				end
				M_STOP_A: begin
					if (m_half) begin
						m_state_q <= M_STOP_B;
					end
				end
				M_STOP_B: begin
					if (m_hi_done) begin
						m_state_q <= M_STOP_C;
					end
				end
				M_STOP_C: begin
					if (m_half) begin
						m_state_q <= M_IDLE; // RULE3
					end
				end
				M_RS_A: begin
					if (m_half) begin
						m_state_q <= M_RS_B;
					end
				end
				M_RS_B: begin
					if (m_hi_done) begin
						m_state_q <= M_START; // RULE4
					end
				end
				default: m_state_q <= M_IDLE;
			endcase
		end
	end

	assign done_d = enable & ((m_state_q == M_HIGH & m_bit_q == BIT_ACK & m_hi_done)
		| (m_state_q == M_STOP_C & m_half));

	logic m_scl_low;
	logic m_sda_low;

	always_comb begin
		m_scl_low = 1'b0;
		m_sda_low = 1'b0;
		case (m_state_q)
			M_START: m_sda_low = 1'b1; // RULE20
			M_LOW, M_HIGH: begin
				m_scl_low = m_state_q == M_LOW; // RULE1 RULE14
				if (m_bit_q == BIT_ACK) begin
					m_sda_low = m_rx_q & ~m_nack_q; // RULE15
				end else begin
					m_sda_low = ~m_rx_q & ~m_shift_q[7]; // RULE9
				end
			end
			M_HOLD, M_RS_A: m_scl_low = 1'b1;
			M_STOP_A: begin
				m_scl_low = 1'b1;
				m_sda_low = 1'b1;
			end
			M_STOP_B: m_sda_low = 1'b1;
			default: m_sda_low = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// slave sequencer
	// ------------------------------------------------------------
	logic [3:0] s_bit_q;
	logic [7:0] s_shift_q;
	logic s_rw_q;
	logic s_gc_q;
	logic s_loaded_q;
	logic s_pend_q;
	logic s_ack_q;
	logic s_match;
	logic s_push;

	assign s_match = (s_shift_q[7:1] == own_address & own_address[6:3] != RESERVED_HI) // RULE12
		| (s_shift_q[7:1] == GC_ADDR & ~s_shift_q[0] & general_call_enable); // RULE10
	assign s_push = s_state_q == S_RX & s_pend_q & slave_ack_enable;
	assign slave_tx_ready = enable & s_state_q == S_TX & ~s_loaded_q;

	// events are taken from sampled lines, hence the sixteen-fold clock need
	always_ff @(posedge ref_clk or negedge rst_n_q) begin // RULE22
		if (!rst_n_q) begin
			s_state_q <= S_IDLE;
			s_bit_q <= BIT_RST;
			s_shift_q <= BYTE_RST;
			s_rw_q <= 1'b0;
			s_gc_q <= 1'b0;
			s_loaded_q <= 1'b0;
			s_pend_q <= 1'b0;
			s_ack_q <= 1'b0;
		end else if (!enable || stop_det || (start_det && m_state_q != M_IDLE)) begin
			s_state_q <= S_IDLE;
			s_pend_q <= 1'b0;
		end else if (start_det) begin
			s_state_q <= S_ADDR; // RULE4
			s_bit_q <= BIT_RST;
			s_pend_q <= 1'b0;
		end else begin
			case (s_state_q)
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						s_shift_q <= {s_shift_q[6:0], sda_s_q}; // RULE9
						s_bit_q <= s_bit_q + 4'h1;
					end
					if (scl_fall && s_bit_q == BIT_ACK) begin
						if (s_state_q == S_RX) begin
							s_pend_q <= 1'b1;
						end else if (s_match && slave_ack_enable) begin
							s_rw_q <= s_shift_q[0]; // RULE6
							s_gc_q <= s_shift_q[7:1] == GC_ADDR;
							s_state_q <= S_ACK; // RULE5 RULE7
						end else begin
							s_state_q <= S_WAIT; // RULE7
						end
					end
					if (s_pend_q) begin
						if (!slave_ack_enable) begin
							s_pend_q <= 1'b0;
							s_state_q <= S_WAIT; // RULE15
						end else if (fifo_in_ready) begin
							s_pend_q <= 1'b0;
							s_state_q <= S_ACK; // RULE14
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						s_bit_q <= BIT_RST;
						s_loaded_q <= 1'b0;
						s_state_q <= s_rw_q ? S_TX : S_RX; // RULE6 RULE10
					end
				end
				S_TX: begin
					if (!s_loaded_q) begin
						if (slave_tx_valid) begin
							s_shift_q <= slave_tx_data;
							s_loaded_q <= 1'b1;
						end
					end else if (scl_fall) begin
						s_shift_q <= {s_shift_q[6:0], 1'b1}; // RULE9
						s_bit_q <= s_bit_q + 4'h1;
						if (s_bit_q == BIT_LAST_DATA) begin
							s_state_q <= S_TXACK; // RULE13
						end
					end
				end
				S_TXACK: begin
					if (scl_rise) begin
						s_ack_q <= ~sda_s_q; // RULE14
					end
					if (scl_fall) begin
						s_bit_q <= BIT_RST;
						s_loaded_q <= 1'b0;
						s_state_q <= s_ack_q ? S_TX : S_WAIT; // RULE15
					end
				end
				S_WAIT, S_IDLE: s_state_q <= s_state_q;
				default: s_state_q <= S_IDLE;
			endcase
		end
	end

	logic s_scl_low;
	logic s_sda_low;

	// stretching: hold the clock while a byte waits for room or data
	assign s_scl_low = (s_state_q == S_RX & s_pend_q) | (s_state_q == S_TX & ~s_loaded_q); // RULE17
	assign s_sda_low = s_state_q == S_ACK | (s_state_q == S_TX & s_loaded_q & ~s_shift_q[7]);

	// ------------------------------------------------------------
	// receive FIFO
	// ------------------------------------------------------------
	logic [7:0] push_data;

	assign push_data = m_push ? {m_shift_q[6:0], sda_s_q} : s_shift_q;

	sync_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(RX_FIFO_DEPTH)
	) u_rx_fifo (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.in_valid(m_push | s_push),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	// ------------------------------------------------------------
	// pin drivers and status
	// ------------------------------------------------------------
	logic scl_oe_n_q;
	logic sda_pre_q;
	logic sda_oe_n_q;
	logic cmd_done_q;
	status_t status_q;

	// data lags clock by one cycle so it never moves near a clock edge
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			scl_oe_n_q <= 1'b1;
			sda_pre_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else begin
			scl_oe_n_q <= ~(enable & (m_scl_low | s_scl_low)); // RULE18
			sda_pre_q <= enable & (m_sda_low | s_sda_low);
			sda_oe_n_q <= ~sda_pre_q; // RULE1 RULE18
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cmd_done_q <= 1'b0;
			status_q <= '0;
		end else begin
			cmd_done_q <= done_d;
			status_q.bus_busy <= bus_busy_q;
			status_q.ack_received <= m_ack_q;
			status_q.addressed <= s_state_q inside {S_ACK, S_RX, S_TX, S_TXACK};
			status_q.general_call <= s_gc_q;
			status_q.slave_read <= s_rw_q;
			status_q.master_ack_seen <= s_ack_q;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = scl_oe_n_q;
	assign sda_oe_n = sda_oe_n_q;
	assign cmd_done = cmd_done_q;
	assign status = status_q;

endmodule
`default_nettype wire

/* dv/two_wire_asserts.sv */
// port checks of the two-wire bus protocol engine
`timescale 1ns/1ps
`default_nettype none
module two_wire_asserts
	import two_wire_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic two_wire_power_off_bit,
	input wire logic [6:0] own_address,
	input wire logic general_call_enable,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire status_t status,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_out,
	input wire logic sda_oe_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ----
	// properties
	// ----
	property p_low_only;
		scl_out == 1'b0 && sda_out == 1'b0;
	endproperty
	a_low_only: assert property (p_low_only) else $error("line driven high");
	property p_off_ready;
		two_wire_power_off_bit |-> !cmd_ready;
	endproperty
	a_off_ready: assert property (p_off_ready) else $error("ready while off");
	property p_off_rel;
		two_wire_power_off_bit [*3] |-> scl_oe_n && sda_oe_n;
	endproperty
	a_off_rel: assert property (p_off_rel) else $error("pins held while off");
	property p_done_gap;
		cmd_done |=> !cmd_done [*8];
	endproperty
	a_done_gap: assert property (p_done_gap) else $error("packets too close");
	// a data line falling with the clock high is a start and must mark the bus busy
	property p_start_busy;
		scl_in && $past(scl_in) && $fell(sda_oe_n) |-> ##[1:8] status.bus_busy;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start not seen");
	property p_stop_free;
		scl_in && $past(scl_in) && $rose(sda_oe_n) |-> ##[1:8] !status.bus_busy;
	endproperty
	a_stop_free: assert property (p_stop_free) else $error("stop not seen");
	property p_reserved;
		$rose(status.addressed) |-> own_address[6:3] != RESERVED_HI;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved answered");
	property p_gc;
		$rose(status.general_call) |-> general_call_enable;
	endproperty
	a_gc: assert property (p_gc) else $error("call while disabled");
	c_done: cover property (cmd_done);
	c_addr: cover property ($rose(status.addressed));
	c_gc: cover property ($rose(status.general_call));
	c_hold: cover property (scl_oe_n && !scl_in);
endmodule
bind two_wire_bus_protocol_engine two_wire_asserts chk (
	.ref_clk, .reset_n, .two_wire_power_off_bit, .own_address,
	.general_call_enable, .cmd_ready, .cmd_done, .status, .scl_in,
	.scl_out, .scl_oe_n, .sda_out, .sda_oe_n
);
`default_nettype wire

/* dv/bus_peer.sv */
// far-side slave on the two-wire bus: acks its address, takes or sends bytes
`timescale 1ns/1ps
`default_nettype none
module bus_peer #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] stretch,
	output logic scl_rel,
	output logic sda_rel,
	output logic [7:0] got,
	output logic nack_seen
);
	localparam logic [7:0] TXB = 8'hC3;
	logic c_q = 1'b1, s_q = 1'b1, act = 1'b0, adr = 1'b0, rd = 1'b0;
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00, st = 8'h00;
	initial begin
		sda_rel = 1'b1;
		got = 8'h00;
		nack_seen = 1'b0;
	end
	// only ever pulls low; release lets the pull-up win
	assign scl_rel = (st == 8'h00);
	always @(posedge clk) begin
		c_q <= scl;
		s_q <= sda;
		if (st != 8'h00) st <= st - 8'h01;
		if (c_q && scl && s_q && !sda) begin
			act <= 1'b1; adr <= 1'b1; rd <= 1'b0; cnt <= 4'h0; sda_rel <= 1'b1; nack_seen <= 1'b0;
		end else if (c_q && scl && !s_q && sda) act <= 1'b0;
		else if (act && !c_q && scl) begin
			sh <= {sh[6:0], sda};
			cnt <= cnt + 4'h1;
			if (cnt == 4'h8 && rd && !adr && sda) nack_seen <= 1'b1;
		end else if (act && c_q && !scl) begin
			st <= stretch;
			if (cnt == 4'h8) begin
				if (adr && sh[7:1] != ADDR) act <= 1'b0;
				else begin
					sda_rel <= rd & !adr;
					if (adr) rd <= sh[0];
					if (!adr && !rd) got <= sh;
				end
			end else if (cnt == 4'h9) begin
				cnt <= 4'h0;
				adr <= 1'b0;
				sda_rel <= (rd && !nack_seen) ? TXB[7] : 1'b1;
			end else if (rd && !adr) sda_rel <= TXB[3'h7 - cnt[2:0]];
		end
	end
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench of the two-wire bus protocol engine
`timescale 1ns/1ps
`default_nettype none
module tb
	import two_wire_pkg::*;
;
	localparam logic [6:0] PA = 7'h2A;
	logic ref_clk = 1'b0, reset_n = 1'b0;
	logic pw_off, gce, aen, cv, cr, cd, rxv, rxr, scl_o, sda_o, scl_oe_n, sda_oe_n;
	logic tb_scl, tb_sda, p_scl, p_sda, nk, scl_q, stv, str;
	logic [7:0] div, rxd, got, stretch;
	logic [1:0] psel;
	logic [6:0] own;
	cmd_t cmd;
	status_t st;
	int n_errors, num_checks, cyc, t_r, per, nb;
	wire logic scl = (scl_oe_n | scl_o) & p_scl & tb_scl;
	wire logic sda = (sda_oe_n | sda_o) & p_sda & tb_sda;
	two_wire_bus_protocol_engine dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .two_wire_power_off_bit(pw_off),
		.bit_rate_divider(div), .prescale_sel(psel), .own_address(own),
		.general_call_enable(gce), .slave_ack_enable(aen), .cmd_valid(cv),
		.cmd_ready(cr), .cmd(cmd), .cmd_done(cd), .slave_tx_valid(stv),
		.slave_tx_ready(str), .slave_tx_data(8'hA5), .rx_valid(rxv), .rx_ready(rxr),
		.rx_data(rxd), .status(st), .scl_in(scl), .scl_out(scl_o),
		.scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_o), .sda_oe_n(sda_oe_n)
	);
	bus_peer #(.ADDR(PA)) peer (
		.clk(ref_clk), .scl(scl), .sda(sda), .stretch(stretch), .scl_rel(p_scl),
		.sda_rel(p_sda), .got(got), .nack_seen(nk)
	);
	always #5 ref_clk = ~ref_clk;
	// ----
	// clock period monitor and hang guard
	// ----
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		scl_q <= scl;
		if (scl && !scl_q) begin
			per <= cyc - t_r;
			t_r <= cyc;
		end
		if (cyc == 60000) begin
			n_errors++;
			results;
		end
	end
	task results;
		if (n_errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	task mc(input op_t o, input logic [7:0] d, input logic n);
		@(posedge ref_clk);
		cv <= 1'b1;
		cmd <= '{o, d, n};
		do @(negedge ref_clk); while (cr !== 1'b1);
		@(posedge ref_clk);
		cv <= 1'b0;
		while (cd !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
	endtask
	task pop(input logic [7:0] e);
		while (rxv !== 1'b1) @(negedge ref_clk);
		chk("rx_data", e, rxd);
		@(posedge ref_clk);
		rxr <= 1'b1;
		@(posedge ref_clk);
		rxr <= 1'b0;
		@(negedge ref_clk);
	endtask
	// ----
	// bench as far-side master, 42-cycle bit, honours clock stretch
	// ----
	task hp;
		repeat (20) @(posedge ref_clk);
	endtask
	task bb(input logic b, output logic v);
		int k;
		@(posedge ref_clk);
		tb_sda <= b;
		hp;
		tb_scl <= 1'b1;
		k = 0;
		do begin @(posedge ref_clk); k++; end while (scl !== 1'b1 && k < 3000);
		chk("scl released", 1, scl);
		hp;
		v = sda;
		tb_scl <= 1'b0;
	endtask
	task bw(input logic [7:0] d, output logic a);
		logic v;
		for (int i = 7; i >= 0; i--) bb(d[i], v);
		bb(1'b1, a);
	endtask
	task bs;
		@(posedge ref_clk);
		tb_sda <= 1'b1;
		tb_scl <= 1'b1;
		hp;
		tb_sda <= 1'b0;
		hp;
		tb_scl <= 1'b0;
	endtask
	task bp;
		@(posedge ref_clk);
		tb_sda <= 1'b0;
		hp;
		tb_scl <= 1'b1;
		hp;
		tb_sda <= 1'b1;
		hp;
	endtask
	// ----
	// scenarios
	// ----
	task t_clk;
		logic [15:0] h;
		for (int p = 0; p < 4; p++) begin
			@(posedge ref_clk);
			psel <= p[1:0];
			h = HALF_BASE + {8'h00, div} * (p == 0 ? PRESC_1 : p == 1 ? PRESC_4 : p == 2 ? PRESC_16 : PRESC_64);
			mc(OP_START, {PA, 1'b0}, 1'b0);
			chk("ack_received", 1, st.ack_received);
			chk("bus_busy", 1, st.bus_busy);
			mc(OP_WRITE, {6'h29, p[1:0]}, 1'b0);
			chk("peer byte", {6'h29, p[1:0]}, got);
			chk("scl period", h * 2, per[15:0]);
			mc(OP_STOP, 8'h00, 1'b0);
			repeat (10) @(negedge ref_clk);
			chk("bus_busy", 0, st.bus_busy);
		end
	endtask
	task t_read;
		// longer than the master's low half, so the high phase must wait for it
		stretch <= 8'hA0;
		mc(OP_START, {PA, 1'b1}, 1'b0);
		mc(OP_READ, 8'h00, 1'b1);
		chk("nack", 1, nk);
		pop(8'hC3);
		mc(OP_STOP, 8'h00, 1'b0);
		stretch <= 8'h00;
	endtask
	task t_rs;
		mc(OP_START, {7'h11, 1'b0}, 1'b0);
		chk("ack_received", 0, st.ack_received);
		mc(OP_START, {PA, 1'b0}, 1'b0);
		chk("ack_received", 1, st.ack_received);
		chk("bus_busy", 1, st.bus_busy);
		mc(OP_WRITE, 8'h3C, 1'b0);
		chk("peer byte", 8'h3C, got);
		mc(OP_STOP, 8'h00, 1'b0);
	endtask
	// fills the receive buffer past its 16 words while the drain stalls
	task t_fifo;
		logic k;
		nb = 0;
		fork
			begin
				bs;
				bw({7'h35, 1'b0}, k);
				chk("slave ack", 0, k);
				for (int i = 0; i < 17; i++) begin
					bw(8'h40 + i[7:0], k);
					nb++;
				end
				bp;
			end
			begin
				wait (nb == 16);
				repeat (600) @(negedge ref_clk);
				chk("held scl", 0, scl);
				chk("addressed", 1, st.addressed);
				for (int i = 0; i < 17; i++) pop(8'h40 + i[7:0]);
			end
		join
	endtask
	// bench reads one byte from the engine's slave transmitter, then refuses more
	task t_stx;
		logic k;
		logic [7:0] r;
		bs;
		bw({7'h35, 1'b1}, k);
		chk("slave ack", 0, k);
		repeat (8) @(negedge ref_clk);
		chk("slave_tx_ready", 1, str);
		@(posedge ref_clk);
		stv <= 1'b1;
		for (int i = 7; i >= 0; i--) bb(1'b1, r[i]);
		bb(1'b1, k);
		stv <= 1'b0;
		chk("slave byte", 8'hA5, r);
		chk("slave_read", 1, st.slave_read);
		bp;
	endtask
	task sl(input logic [6:0] o, input logic [6:0] a, input logic g, input logic e, input logic x);
		logic k;
		@(posedge ref_clk);
		own <= o;
		gce <= g;
		aen <= e;
		bs;
		bw({a, 1'b0}, k);
		chk("slave ack", x, k);
		if (x == 1'b0) begin
			bw(8'h5C, k);
			pop(8'h5C);
		end
		bp;
	endtask
	task t_off;
		@(posedge ref_clk);
		pw_off <= 1'b1;
		repeat (4) @(negedge ref_clk);
		chk("cmd_ready", 0, cr);
		chk("oe_n", 2'b11, {scl_oe_n, sda_oe_n});
		@(posedge ref_clk);
		pw_off <= 1'b0;
	endtask
	initial begin
		stretch = 8'h00; tb_scl = 1'b1; tb_sda = 1'b1; cv = 1'b0; cmd = '0; rxr = 1'b0; stv = 1'b0;
		pw_off = 1'b0; div = 8'h01; psel = 2'b00; own = 7'h35; gce = 1'b1; aen = 1'b1;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
		t_clk;
		t_rs;
		t_read;
		t_fifo;
		t_stx;
		sl(7'h35, 7'h00, 1'b1, 1'b1, 1'b0);
		sl(7'h35, 7'h00, 1'b0, 1'b1, 1'b1);
		sl(7'h35, 7'h35, 1'b1, 1'b0, 1'b1);
		sl(7'h7A, 7'h7A, 1'b1, 1'b1, 1'b1);
		t_off;
		results;
	end
endmodule
`default_nettype wire
